/* File: fault_monitor_alert.sv */
// Fault alert monitor: sticky supply and event flags, masks, alert pin and link hold.
// Summary of operation
// (RULE_01) Alert pin is open-drain, low when any enabled flag is set.
// (RULE_02) Every source has its own mask bit gating the alert; here external events share one bit, power-on reset shares the core one.
// (RULE_03) Every alerting source sets its own readable status flag.
// (RULE_04) Overvoltage on three rails only raises the alert; operation continues.
// (RULE_05) Overvoltage flags set only while the pixel clock is valid.
// (RULE_06) Each overvoltage flag clears when the host reads it.
// (RULE_07) Analog or I/O undervoltage warns, then resets at the lower level.
// (RULE_08) Core rail undervoltage alerts and resets at once.
// (RULE_09) The I/O rail has undervoltage monitoring only, no overvoltage flag.
// (RULE_10) After undervoltage reset, registers return to defaults; host reprograms.
// (RULE_11) Undervoltage flags clear on reads of the power status registers.
// (RULE_12) Host reads the first power status before the second when both set.
// (RULE_13) Undervoltage status survives the reset so the host finds the rail.
// (RULE_14) Alert pin floats during and after undervoltage reset until reconfigured.
// (RULE_15) Start-up is held until every supply rail is within limits.
// (RULE_16) Host stops traffic, then sets link hold to idle the device.
// (RULE_17) Host configures a feature fully before enabling it.
// (RULE_18) Host clears link hold, waits for lock, then starts traffic.
// (RULE_19) Host disables, reconfigures and re-enables a feature in operation.
// (RULE_20) Host tolerates lost control access during undervoltage events.
// (RULE_21) While link hold is set, link logic stays reset; registers stay reachable.
// (RULE_22) Lock output goes high once the serial link locks.
// (RULE_23) Every status flag is sticky until read-cleared; here overvoltage and event flags also clear whenever the core leaves run.
`timescale 1ns/1ps
`default_nettype none
`include "fault_monitor_map.svh"

module fault_monitor_alert #(
	parameter int unsigned EXT_EVENTS = 4
) (
	input  wire logic                             clk,
	input  wire logic                             rstn,
	input  wire logic [`FM_ADDR_W-1:0]            addr,
	input  wire logic [`FM_DATA_W-1:0]            wdata,
	input  wire logic                             wr,
	input  wire logic                             rd,
	output logic      [`FM_DATA_W-1:0]            rdata,
	input  wire fault_monitor_pkg::ov_comp_t      ov_comp,
	input  wire fault_monitor_pkg::uv_comp_t      uv_comp,
	input  wire logic                             supplies_ok,
	input  wire logic                             pixel_clock_detector,
	input  wire logic                             link_locked_raw,
	input  wire logic [EXT_EVENTS-1:0]            ext_event,
	output logic                                  fault_alert_n_out,
	output logic                                  fault_alert_n_oe,
	output logic                                  device_reset_n,
	output logic                                  link_reset_n,
	output logic                                  lock
);

	localparam int unsigned SETTLE_CYC_RAW = (`FM_SETTLE_NS + `FM_CLK_NS - 1) / `FM_CLK_NS;
	localparam int unsigned SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: comparators and detectors are asynchronous to clk.

	// Bit positions inside the synchroniser word; the concatenation below must match them.
	localparam int unsigned OV_AT   = 5;
	localparam int unsigned SUP_AT  = 8;
	localparam int unsigned PCLK_AT = 9;
	localparam int unsigned LOCK_AT = 10;
	localparam int unsigned EXT_AT  = 11;
	localparam int unsigned SW      = EXT_AT + EXT_EVENTS;
	logic [SW-1:0] sync_a;
	logic [SW-1:0] sync_b;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {ext_event, link_locked_raw, pixel_clock_detector, supplies_ok, ov_comp, uv_comp};
			sync_b <= sync_a;
		end
	end

	fault_monitor_pkg::uv_comp_t uv_s;
	fault_monitor_pkg::ov_comp_t ov_s;
	logic                        supplies_ok_s;
	logic                        pclk_ok_s;
	logic                        locked_s;
	logic [EXT_EVENTS-1:0]       ext_s;

	assign uv_s          = sync_b[OV_AT-1:0];
	assign ov_s          = sync_b[SUP_AT-1:OV_AT];
	assign supplies_ok_s = sync_b[SUP_AT];
	assign pclk_ok_s     = sync_b[PCLK_AT];
	assign locked_s      = sync_b[LOCK_AT];
	assign ext_s         = sync_b[SW-1:EXT_AT];

	////////////////////////////////////////////////////////////////////////////
	// Power manager.

	fault_monitor_pkg::pwr_state_t state;
	logic [15:0]                   settle_cnt;
	logic                          uv_reset;

	// (RULE_07) Reset level trip.
	// (RULE_08) Core trip is immediate.
	assign uv_reset = uv_s.analog_reset | uv_s.io_reset | uv_s.core_low;

	// (RULE_15) Hold start-up until rails good.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state      <= fault_monitor_pkg::PWR_WAIT;
			settle_cnt <= '0;
		end else if (uv_reset || !supplies_ok_s) begin
			state      <= fault_monitor_pkg::PWR_WAIT;
			settle_cnt <= '0;
		end else begin
			unique case (state)
				fault_monitor_pkg::PWR_WAIT: begin
					state      <= fault_monitor_pkg::PWR_SETTLE;
					settle_cnt <= '0;
				end
				fault_monitor_pkg::PWR_SETTLE: begin
					if (settle_cnt == 16'(SETTLE_CYC - 1)) begin
						state <= fault_monitor_pkg::PWR_RUN;
					end
					settle_cnt <= settle_cnt + 16'h0001;
				end
				fault_monitor_pkg::PWR_RUN: begin
					state <= fault_monitor_pkg::PWR_RUN;
				end
				default: begin
					state <= fault_monitor_pkg::PWR_WAIT;
				end
			endcase
		end
	end

	logic running;
	assign running        = (state == fault_monitor_pkg::PWR_RUN);
	assign device_reset_n = running;

	////////////////////////////////////////////////////////////////////////////
	// Control registers: reset to defaults whenever the core is not running.

	logic [7:0] ctrl;
	logic [7:0] mask;
	logic       wr_ok;
	logic       rd_ok;
	assign wr_ok = wr & running;
	assign rd_ok = rd & running;

	// One address decode shared by every write and every clearing read.
	function automatic logic hit(
		input logic                  strobe,
		input logic [`FM_ADDR_W-1:0] a,
		input logic [`FM_ADDR_W-1:0] target
	);
		return strobe && (a == target);
	endfunction

	// (RULE_10) Defaults after undervoltage reset.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= `FM_CTRL_RESET;
		end else if (!running) begin
			ctrl <= `FM_CTRL_RESET;
		end else if (hit(wr_ok, addr, `FM_REG_CTRL)) begin
			ctrl <= {6'h00, wdata[1:0]};
		end
	end

	// (RULE_02) Masks default to enabled.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mask <= `FM_MASK_RESET;
		end else if (!running) begin
			mask <= `FM_MASK_RESET;
		end else if (hit(wr_ok, addr, `FM_REG_MASK)) begin
			mask <= wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky status flags; a set in the read cycle wins over the clear.

	logic [2:0] ov_flags;
	logic [2:0] ov_set;
	logic       rd_ov;

	// (RULE_05) Gate on valid pixel clock.
	// (RULE_04) Overvoltage only flags.
	// (RULE_09) No I/O overvoltage input.
	assign ov_set = pclk_ok_s ? {ov_s.analog_high, ov_s.main_high, ov_s.core_high} : 3'h0;
	assign rd_ov  = hit(rd_ok, addr, `FM_REG_OV_STATUS);

	// (RULE_06) Clear on read.
	// (RULE_23) Sticky until read.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ov_flags <= 3'h0;
		end else if (!running) begin
			ov_flags <= 3'h0;
		end else begin
			ov_flags <= (rd_ov ? 3'h0 : ov_flags) | ov_set;
		end
	end

	// First power status: per-domain supply-bad flags {core, io, analog} and power-on-reset flag.
	logic [2:0] bad_flags;
	logic       por_flag;
	logic       cmp_flag;
	logic       bad_io_cmp;
	logic       rd_first;
	logic       rd_second;
	logic       first_seen;

	assign rd_first  = hit(rd_ok, addr, `FM_REG_PWR_FIRST);
	assign rd_second = hit(rd_ok, addr, `FM_REG_PWR_SECOND);

	// Undervoltage flags live outside the run reset so the cause survives the reset.
	// (RULE_13) Survives undervoltage reset.
	// (RULE_11) Cleared by power status reads.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bad_flags <= 3'h0;
		end else begin
			bad_flags <= (rd_first ? 3'h0 : bad_flags) | {uv_s.core_low, uv_s.io_warn, uv_s.analog_warn};
		end
	end

	// (RULE_11) Power-on-reset flag.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			por_flag <= 1'b0;
		end else begin
			por_flag <= (rd_first ? 1'b0 : por_flag) | uv_reset;
		end
	end

	// (RULE_11) I/O copy, second register.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bad_io_cmp <= 1'b0;
		end else begin
			bad_io_cmp <= (rd_second ? 1'b0 : bad_io_cmp) | uv_s.io_warn;
		end
	end

	// A new undervoltage reset forgets an earlier first read, so the order is judged afresh.
	// (RULE_12) Order of status reads.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			first_seen <= 1'b0;
		end else if (rd_first) begin
			first_seen <= 1'b1;
		end else if (rd_second || uv_reset) begin
			first_seen <= 1'b0;
		end
	end

	// (RULE_12) Compare clears after first read.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmp_flag <= 1'b0;
		end else if (rd_second && (!por_flag || first_seen)) begin
			cmp_flag <= uv_s.analog_warn | uv_s.io_warn;
		end else begin
			cmp_flag <= cmp_flag | uv_s.analog_warn | uv_s.io_warn;
		end
	end

	logic [EXT_EVENTS-1:0] ext_flags;
	logic                  rd_evt;
	assign rd_evt = hit(rd_ok, addr, `FM_REG_EVT_STATUS);

	// (RULE_03) Flag for other event sources.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ext_flags <= '0;
		end else if (!running) begin
			ext_flags <= '0;
		end else begin
			ext_flags <= (rd_evt ? '0 : ext_flags) | ext_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Alert pin.

	logic any_alert;
	// (RULE_02) Per-source masks; external events share one bit.
	// (RULE_01) OR of enabled flags.
	assign any_alert = (mask[`FM_MASK_OV_CORE]   & ov_flags[`FM_OV_CORE])
	                 | (mask[`FM_MASK_OV_MAIN]   & ov_flags[`FM_OV_MAIN])
	                 | (mask[`FM_MASK_OV_ANALOG] & ov_flags[`FM_OV_ANALOG])
	                 | (mask[`FM_MASK_UV_ANALOG] & bad_flags[0])
	                 | (mask[`FM_MASK_UV_IO]     & bad_flags[1])
	                 | (mask[`FM_MASK_UV_CORE]   & (bad_flags[2] | por_flag))
	                 | (mask[`FM_MASK_UV_CMP]    & cmp_flag)
	                 | (mask[`FM_MASK_EXT]       & (|ext_flags));

	// (RULE_14) Pin floats until alert function selected.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fault_alert_n_oe <= 1'b0;
		end else begin
			fault_alert_n_oe <= running & ctrl[`FM_CTRL_ALERT_PIN] & any_alert;
		end
	end
	// Only the enable toggles; the data side of the open-drain pin stays low.
	assign fault_alert_n_out = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// Link hold and lock.

	// (RULE_21) Link held in reset, registers live.
	assign link_reset_n = running & ~ctrl[`FM_CTRL_LINK_HOLD];

	// Lock drops the cycle after the link is held, so a stale lock reaches the host for one cycle at most.
	// (RULE_22) Lock output follows link lock.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lock <= 1'b0;
		end else begin
			lock <= link_reset_n & locked_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the strobe; unmapped addresses read zero.
	// Reads are answered outside run too, so the host can still find the failed rail.

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= '0;
		end else if (rd) begin
			unique case (addr)
				`FM_REG_CTRL:        rdata <= ctrl;
				`FM_REG_OV_STATUS:   rdata <= {5'h00, ov_flags};
				`FM_REG_PWR_FIRST:   rdata <= {4'h0, por_flag, bad_flags};
				`FM_REG_PWR_SECOND:  rdata <= {6'h00, cmp_flag, bad_io_cmp};
				`FM_REG_MASK:        rdata <= mask;
				`FM_REG_LINK_STATUS: rdata <= {5'h00, state == fault_monitor_pkg::PWR_RUN, lock, link_reset_n};
				`FM_REG_EVT_STATUS:  rdata <= 8'(ext_flags);
				default:             rdata <= 8'h00;
			endcase
		end else begin
			rdata <= '0;
		end
	end

endmodule // fault_monitor_alert
`default_nettype wire

/* File: fault_monitor_map.svh */
// Register offsets, field positions, reset values and timing values in nanoseconds of the fault monitor.
`ifndef FAULT_MONITOR_MAP_SVH
`define FAULT_MONITOR_MAP_SVH

`define FM_ADDR_W            8
`define FM_DATA_W            8

`define FM_REG_CTRL          8'h00
`define FM_REG_OV_STATUS     8'h01
`define FM_REG_PWR_FIRST     8'h02
`define FM_REG_PWR_SECOND    8'h03
`define FM_REG_MASK          8'h04
`define FM_REG_LINK_STATUS   8'h05
`define FM_REG_EVT_STATUS    8'h06

`define FM_CTRL_LINK_HOLD    0
`define FM_CTRL_ALERT_PIN    1

`define FM_OV_CORE           0
`define FM_OV_MAIN           1
`define FM_OV_ANALOG         2

`define FM_POWER_STATUS_SECOND_BAD          0
`define FM_POWER_STATUS_SECOND_CMP          1

`define FM_MASK_OV_CORE      0
`define FM_MASK_OV_MAIN      1
`define FM_MASK_OV_ANALOG    2
`define FM_MASK_UV_ANALOG    3
`define FM_MASK_UV_IO        4
`define FM_MASK_UV_CORE      5
`define FM_MASK_UV_CMP       6
`define FM_MASK_EXT          7

`define FM_CTRL_RESET        8'h01
`define FM_MASK_RESET        8'hff

`define FM_SETTLE_NS         1000
`define FM_CLK_NS            50

`endif

/* File: fault_monitor_pkg.sv */
// Types shared by the fault monitor.
`default_nettype none
package fault_monitor_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic analog_warn;
		logic io_warn;
		logic analog_reset;
		logic io_reset;
		logic core_low;
	} uv_comp_t;

	typedef struct packed {
		logic analog_high;
		logic main_high;
		logic core_high;
	} ov_comp_t;

	typedef enum logic [1:0] {
		PWR_WAIT   = 2'b00,
		PWR_SETTLE = 2'b01,
		PWR_RUN    = 2'b11
	} pwr_state_t;

endpackage
`default_nettype wire

/* File: fault_alert_monitor.sv */
// Concurrent checks on the ports of the fault alert monitor.
`timescale 1ns/1ps
`default_nettype none
module fault_alert_monitor #(
	parameter int unsigned EXT_EVENTS = 4
) (
	input wire logic                        clk,
	input wire logic                        rstn,
	input wire logic [7:0]                  addr,
	input wire logic [7:0]                  wdata,
	input wire logic                        wr,
	input wire logic                        rd,
	input wire logic [7:0]                  rdata,
	input wire fault_monitor_pkg::ov_comp_t ov_comp,
	input wire fault_monitor_pkg::uv_comp_t uv_comp,
	input wire logic                        supplies_ok,
	input wire logic                        pixel_clock_detector,
	input wire logic                        link_locked_raw,
	input wire logic [EXT_EVENTS-1:0]       ext_event,
	input wire logic                        fault_alert_n_out,
	input wire logic                        fault_alert_n_oe,
	input wire logic                        device_reset_n,
	input wire logic                        link_reset_n,
	input wire logic                        lock
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data not zero outside the answer cycle");
	a_alert_low: assert property (fault_alert_n_out == 1'b0)
		else $error("alert pin data is not low");
	a_hold_link: assert property (link_reset_n |-> device_reset_n)
		else $error("link released while device held in reset");
	a_lock_drop: assert property (!link_reset_n |=> !lock)
		else $error("lock shown while link held");
	a_lock_rise: assert property ((link_reset_n && link_locked_raw) [*4] |=> lock)
		else $error("lock output missing after link lock");
	a_start_held: assert property ($rose(device_reset_n) |-> $past(supplies_ok, 20))
		else $error("start-up without settled supplies");
	a_core_reset: assert property (uv_comp.core_low [*4] |=> !device_reset_n)
		else $error("core undervoltage did not reset");
	a_no_reset: assert property ((device_reset_n && supplies_ok && !uv_comp.analog_reset
		&& !uv_comp.io_reset && !uv_comp.core_low) [*4] |=> device_reset_n)
		else $error("reset without a reset-level cause");
	a_pin_float: assert property (!device_reset_n [*2] |-> !fault_alert_n_oe)
		else $error("alert pin driven during device reset");
	c_run: cover property ($rose(device_reset_n));
	c_alert: cover property ($rose(fault_alert_n_oe));
	c_lock: cover property ($rose(lock));
endmodule // fault_alert_monitor

bind fault_monitor_alert fault_alert_monitor #(.EXT_EVENTS(EXT_EVENTS)) u_mon (.clk(clk), .rstn(rstn),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ov_comp(ov_comp), .uv_comp(uv_comp),
	.supplies_ok(supplies_ok), .pixel_clock_detector(pixel_clock_detector), .link_locked_raw(link_locked_raw),
	.ext_event(ext_event), .fault_alert_n_out(fault_alert_n_out), .fault_alert_n_oe(fault_alert_n_oe),
	.device_reset_n(device_reset_n), .link_reset_n(link_reset_n), .lock(lock));
`default_nettype wire

/* File: host_alert_watch.sv */
// Host side of the open-drain alert line.
`timescale 1ns/1ps
`default_nettype none
module host_alert_watch (
	input  wire logic clk,
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output logic      line,
	output logic      seen
);
	// The board pull-up sets the level whenever nobody pulls the pin low.
	assign line = pin_oe ? pin_out : 1'b1;
	// keeps watching alert
	// A low level is latched each cycle so the host sees alerts even while bus access is lost.
	always_ff @(posedge clk) seen <= !line;
endmodule // host_alert_watch
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the fault alert monitor.
`timescale 1ns/1ps
`default_nettype none
`include "fault_monitor_map.svh"
module testbench;
	logic                        clk, rstn, wr, rd, supplies_ok, pck, lraw;
	logic [7:0]                  addr, wdata, rdata, d, e;
	fault_monitor_pkg::ov_comp_t ov_comp;
	fault_monitor_pkg::uv_comp_t uv_comp;
	logic [3:0]                  ext_event;
	logic                        a_out, a_oe, dev_n, link_n, lock, line, seen;
	logic [2:0]                  v;
	int                          err_total, checks;
	fault_monitor_alert #(.EXT_EVENTS(4)) u_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .ov_comp(ov_comp), .uv_comp(uv_comp), .supplies_ok(supplies_ok),
		.pixel_clock_detector(pck), .link_locked_raw(lraw), .ext_event(ext_event), .fault_alert_n_out(a_out),
		.fault_alert_n_oe(a_oe), .device_reset_n(dev_n), .link_reset_n(link_n), .lock(lock));
	host_alert_watch u_host (.clk(clk), .pin_out(a_out), .pin_oe(a_oe), .line(line), .seen(seen));
	initial clk = 1'b0;
	always #25 clk = ~clk;
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] ov_exp(input logic [2:0] s, input logic pc);
		return pc ? {5'h00, s} : 8'h00;
	endfunction
	task automatic chk(input logic [7:0] seen_v, input logic [7:0] exp);
		checks++;
		if (seen_v !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen_v, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk);
		addr <= a;
		wdata <= x;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Data is taken just after the answer edge, where it has settled.
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] x);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 x = rdata;
	endtask
	task automatic wait_run(input logic lvl, input int n);
		for (int i = 0; i < n && dev_n !== lvl; i++) @(negedge clk);
		chk(8'(dev_n), 8'(lvl));
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		test_done();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{rstn, wr, rd, pck, lraw, addr, wdata, ext_event} = '0;
		ov_comp = '0;
		uv_comp = '0;
		supplies_ok = 1'b1;
		err_total = 0;
		checks = 0;
		void'($urandom(32'h6c97));
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		wait_run(1'b1, 100);
		rd_reg(`FM_REG_CTRL, d);
		chk(d, `FM_CTRL_RESET);
		rd_reg(`FM_REG_MASK, d);
		chk(d, `FM_MASK_RESET);
		chk(8'(link_n), 8'h00);
		rd_reg(`FM_REG_PWR_FIRST, d);
		rd_reg(`FM_REG_PWR_SECOND, d);
		wr_reg(`FM_REG_MASK, `FM_MASK_RESET);
		wr_reg(`FM_REG_CTRL, 8'h02);
		lraw <= 1'b1;
		repeat (6) @(posedge clk);
		chk({6'h00, a_oe, lock}, 8'h01);
		for (int i = 0; i < 5; i++) begin
			pck <= i[0];
			v = 3'($urandom_range(7, 1));
			ov_comp <= fault_monitor_pkg::ov_comp_t'(v);
			repeat (4) @(posedge clk);
			ov_comp <= '0;
			repeat (3) @(posedge clk);
			chk({7'h00, a_oe}, {7'h00, i[0]});
			rd_reg(`FM_REG_OV_STATUS, d);
			chk(d, ov_exp(v, i[0]));
			rd_reg(`FM_REG_OV_STATUS, d);
			chk(d, 8'h00);
			chk({6'h00, dev_n, line}, 8'h03);
		end
		wr_reg(`FM_REG_CTRL, 8'h00);
		wr_reg(`FM_REG_MASK, 8'hfe);
		wr_reg(`FM_REG_CTRL, 8'h02);
		pck <= 1'b1;
		ov_comp <= fault_monitor_pkg::ov_comp_t'(3'b001);
		repeat (5) @(posedge clk);
		ov_comp <= '0;
		chk({7'h00, a_oe}, 8'h00);
		rd_reg(`FM_REG_OV_STATUS, d);
		chk(d, 8'h01);
		wr_reg(`FM_REG_MASK, `FM_MASK_RESET);
		e = 8'($urandom_range(15, 1));
		ext_event <= e[3:0];
		repeat (4) @(posedge clk);
		ext_event <= '0;
		repeat (3) @(posedge clk);
		chk({7'h00, a_oe}, 8'h01);
		rd_reg(`FM_REG_EVT_STATUS, d);
		chk(d, e);
		wr_reg(`FM_REG_CTRL, 8'h03);
		repeat (2) @(posedge clk);
		chk({6'h00, link_n, lock}, 8'h00);
		uv_comp.analog_warn <= 1'b1;
		repeat (5) @(posedge clk);
		uv_comp.analog_warn <= 1'b0;
		chk({6'h00, dev_n, a_oe}, 8'h03);
		rd_reg(`FM_REG_PWR_FIRST, d);
		chk(d & 8'h01, 8'h01);
		chk(8'(seen), 8'h01);
		uv_comp.core_low <= 1'b1;
		wait_run(1'b0, 6);
		repeat (2) @(posedge clk);
		chk({6'h00, a_oe, line}, 8'h01);
		uv_comp.core_low <= 1'b0;
		wait_run(1'b1, 100);
		rd_reg(`FM_REG_CTRL, d);
		chk(d, `FM_CTRL_RESET);
		chk(8'(lock), 8'h00);
		rd_reg(`FM_REG_PWR_SECOND, d);
		chk(d & 8'h02, 8'h02);
		rd_reg(`FM_REG_PWR_SECOND, d);
		chk(d & 8'h02, 8'h02);
		rd_reg(`FM_REG_PWR_FIRST, d);
		chk(d & 8'h0c, 8'h0c);
		rd_reg(`FM_REG_PWR_SECOND, d);
		rd_reg(`FM_REG_PWR_FIRST, d);
		chk(d & 8'h07, 8'h00);
		rd_reg(`FM_REG_PWR_SECOND, d);
		chk(d & 8'h03, 8'h00);
		rd_reg(8'h7f, d);
		chk(d, 8'h00);
		test_done();
	end
endmodule // testbench
`default_nettype wire
